// ===== rtl/gpl_params.svh
// register indices, field positions, masks and reset values of the port block
`ifndef GPL_PARAMS_SVH
`define GPL_PARAMS_SVH

// word indices; byte address on the bus is four times the index
`define GPL_IDX_P0          16'hFF00
`define GPL_IDX_P1          16'hFF01
`define GPL_IDX_P2          16'hFF02
`define GPL_IDX_P3          16'hFF03
`define GPL_IDX_P4          16'hFF04
`define GPL_IDX_P6          16'hFF06
`define GPL_IDX_P7          16'hFF07
`define GPL_IDX_P12         16'hFF0C
`define GPL_IDX_DRV6        16'hFF2A
`define GPL_IDX_PU0         16'hFF30
`define GPL_IDX_PU1         16'hFF31
`define GPL_IDX_PU3         16'hFF33
`define GPL_IDX_PU4         16'hFF34
`define GPL_IDX_PU6         16'hFF36
`define GPL_IDX_PU7         16'hFF37
`define GPL_IDX_PULLUP_SEL_PORT12        16'hFF3C
`define GPL_IDX_THR6        16'hFF3E
`define GPL_IDX_RSTFN       16'hFF41

// port slots inside the block
`define GPL_SLOT_P2         3'h2
`define GPL_SLOT_P6         3'h5
`define GPL_SLOT_P12        3'h7

// writable, readable and fixed masks
`define GPL_MASK_FULL       8'hFF
`define GPL_MASK_NONE       8'h00
`define GPL_LATCH_MASK_P12  8'h01
`define GPL_P12_RO_MASK     8'h3E
`define GPL_P12_RD_MASK     8'h3F
`define GPL_P12_OSC_MAIN    8'h06
`define GPL_P12_OSC_SUB     8'h18
`define GPL_PULL_MASK_P12   8'h21
`define GPL_DRV6_MASK       8'h0F
`define GPL_THR6_MASK       8'h03
`define GPL_RSTFN_MASK      8'h01

// field positions
`define GPL_RESET_PIN_SELECT_BIT_BIT        0
`define GPL_RSTPIN_BIT      5

// reset values
`define GPL_LATCH_RST       8'h00
`define GPL_PULL_RST        8'h00
`define GPL_PULL_RST_P12    8'h20
`define GPL_MISC_RST        8'h00
// reset pin idles high; the sync starts there so no false reset request
`define GPL_SYNC_IDLE       64'h2000_0000_0000_0000

`endif

// ===== rtl/gpl_pkg.sv
// types shared by the port block
package gpl_pkg;

    typedef enum logic [2:0] {
        GPL_K_LATCH = 3'h0,
        GPL_K_PULL  = 3'h1,
        GPL_K_DRV6  = 3'h2,
        GPL_K_THR6  = 3'h3,
        GPL_K_RSTFN = 3'h4
    } gpl_kind_type;

    typedef logic [7:0][7:0] gpl_bytes_type;

    typedef struct packed {
        logic         valid;
        gpl_kind_type kind;
        logic [2:0]   slot;
    } gpl_dec_type;

    typedef struct packed {
        gpl_bytes_type in_mode;
        gpl_bytes_type alt_out;
    } gpl_pin_ctrl_type;

    typedef struct packed {
        gpl_bytes_type out;
        gpl_bytes_type oe;
        gpl_bytes_type pull;
    } gpl_pad_type;

endpackage

// ===== rtl/gpl_pin_sync.sv
// three-stage pin synchroniser, a change is taken once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module gpl_pin_sync #(
    parameter int W = 64
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // pins and clean levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            sync_out <= '0;
        end
        else
        begin
            s1_reg   <= async_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            // disagreeing bits keep their old level
            sync_out <= (s2_reg & ~(s2_reg ^ s3_reg))
                      | (sync_out & (s2_reg ^ s3_reg));
        end
    end

endmodule

`default_nettype wire

// ===== rtl/gpl_port_ctrl.sv
// port latches, pull-up selection and port-6 / reset-pin options behind apb
//
// Functional notes
// RQ1 - latch drives pin in output mode
// RQ2 - read gives pin in input, latch otherwise
// RQ3 - input-mode write updates latch, pin undriven
// RQ4 - software avoids latch of analog input pins
// RQ5 - oscillator-shared port-12 pins read zero
// RQ6 - port-12 bits one to five read-only
// RQ7 - reset clears every port latch
// RQ8 - pull-up needs select bit and input mode
// RQ9 - no pull-up on output or alternate output
// RQ10 - select one connects, zero disconnects pull-up
// RQ11 - pull-ups reset zero, port-12 resets 20H
// RQ12 - port-6 input threshold per pin 60, 61
// RQ13 - port-6 drive type: cmos or open drain
// RQ14 - software sets open drain for i2c
// RQ15 - software clears pin-60 open drain for uart
// RQ16 - bit and byte accesses all accepted
// RQ17 - reset pin mode zero: external reset
// RQ18 - reset pin mode one: input-only port
// RQ19 - fixed-zero bits read zero, ignore writes
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

`include "gpl_params.svh"

module gpl_port_ctrl (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [17:0]               paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // direction and routing from the mode registers
    input  wire gpl_pkg::gpl_pin_ctrl_type pin_ctrl,
    input  wire logic                      main_osc_active,
    input  wire logic                      sub_osc_active,
    // pads
    input  wire gpl_pkg::gpl_bytes_type    pin_in,
    output gpl_pkg::gpl_pad_type           pad,
    output logic [1:0]                     smbus_input_sel,
    output logic                           ext_reset_req
);

    ////////////////////////////////////////////////////////////////////////
    // decode

    function automatic gpl_pkg::gpl_dec_type decode(input logic [17:0] a);
        gpl_pkg::gpl_dec_type d;
        d.valid = (a[1:0] == 2'h0);
        d.kind  = gpl_pkg::GPL_K_LATCH;
        d.slot  = 3'h0;
        unique case (a[17:2])
            `GPL_IDX_P0:    d.slot = 3'h0;
            `GPL_IDX_P1:    d.slot = 3'h1;
            `GPL_IDX_P2:    d.slot = 3'h2;
            `GPL_IDX_P3:    d.slot = 3'h3;
            `GPL_IDX_P4:    d.slot = 3'h4;
            `GPL_IDX_P6:    d.slot = 3'h5;
            `GPL_IDX_P7:    d.slot = 3'h6;
            `GPL_IDX_P12:   d.slot = 3'h7;
            `GPL_IDX_PU0:
            begin
                d.kind = gpl_pkg::GPL_K_PULL;
                d.slot = 3'h0;
            end
            `GPL_IDX_PU1:
            begin
                d.kind = gpl_pkg::GPL_K_PULL;
                d.slot = 3'h1;
            end
            `GPL_IDX_PU3:
            begin
                d.kind = gpl_pkg::GPL_K_PULL;
                d.slot = 3'h3;
            end
            `GPL_IDX_PU4:
            begin
                d.kind = gpl_pkg::GPL_K_PULL;
                d.slot = 3'h4;
            end
            `GPL_IDX_PU6:
            begin
                d.kind = gpl_pkg::GPL_K_PULL;
                d.slot = 3'h5;
            end
            `GPL_IDX_PU7:
            begin
                d.kind = gpl_pkg::GPL_K_PULL;
                d.slot = 3'h6;
            end
            `GPL_IDX_PULLUP_SEL_PORT12:
            begin
                d.kind = gpl_pkg::GPL_K_PULL;
                d.slot = 3'h7;
            end
            `GPL_IDX_DRV6:  d.kind = gpl_pkg::GPL_K_DRV6;
            `GPL_IDX_THR6:  d.kind = gpl_pkg::GPL_K_THR6;
            `GPL_IDX_RSTFN: d.kind = gpl_pkg::GPL_K_RSTFN;
            default:        d.valid = 1'b0;
        endcase
        return d;
    endfunction

    // writable bits of a latch slot; port 12 keeps only bit 0
    function automatic logic [7:0] latch_mask(input logic [2:0] s);
        return (s == `GPL_SLOT_P12) ? `GPL_LATCH_MASK_P12 : `GPL_MASK_FULL;
    endfunction

    // writable bits of a pull-up slot; port 2 has no pull-ups
    function automatic logic [7:0] pull_mask(input logic [2:0] s);
        logic [7:0] m;
        m = `GPL_MASK_FULL;
        if (s == `GPL_SLOT_P12)
            m = `GPL_PULL_MASK_P12;
        else if (s == `GPL_SLOT_P2)
            m = `GPL_MASK_NONE;
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    gpl_pkg::gpl_dec_type  dec;
    gpl_pkg::gpl_bytes_type latch_reg;
    gpl_pkg::gpl_bytes_type pull_sel_reg;
    gpl_pkg::gpl_bytes_type pin_sync;
    gpl_pkg::gpl_bytes_type sync_raw;
    gpl_pkg::gpl_bytes_type eff_in;
    gpl_pkg::gpl_bytes_type od_sel;
    logic [7:0]             drv6_reg;
    logic [7:0]             thr6_reg;
    logic [7:0]             rstfn_reg;
    logic [7:0]             rd_value;
    logic                   wr_fire;
    logic                   byte_wr;
    logic                   rd_fire;

    assign dec     = decode(paddr);
    // the slave answers one cycle into the access phase
    assign rd_fire = psel && penable && !pready;
    assign wr_fire = psel && penable && pready && pwrite && dec.valid;
    // byte lane 0 carries every register; a bit access is a byte rmw
    assign byte_wr = wr_fire && pstrb[0]; // see RQ16

    gpl_pin_sync #(
        .W (64)
    ) u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in (pin_in ^ `GPL_SYNC_IDLE),
        .sync_out (sync_raw)
    );

    // pin 125 is stored inverted so reset leaves it at its idle level
    assign pin_sync = sync_raw ^ `GPL_SYNC_IDLE; // see RQ17

    ////////////////////////////////////////////////////////////////////////
    // port latches

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            latch_reg <= {8{`GPL_LATCH_RST}}; // see RQ7
        end
        else if (byte_wr && dec.kind == gpl_pkg::GPL_K_LATCH)
        begin
            // stored even in input mode; pin follows only in output mode
            latch_reg[dec.slot] <= pwdata[7:0] & latch_mask(dec.slot); // see RQ3
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pull-up selection

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pull_sel_reg <= {`GPL_PULL_RST_P12, {7{`GPL_PULL_RST}}}; // see RQ11
        end
        else if (byte_wr && dec.kind == gpl_pkg::GPL_K_PULL)
        begin
            pull_sel_reg[dec.slot] <= pwdata[7:0] & pull_mask(dec.slot); // see RQ19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port-6 options and reset pin mode

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            drv6_reg  <= `GPL_MISC_RST;
            thr6_reg  <= `GPL_MISC_RST;
            rstfn_reg <= `GPL_MISC_RST; // see RQ17
        end
        else if (byte_wr)
        begin
            if (dec.kind == gpl_pkg::GPL_K_DRV6)
                drv6_reg <= pwdata[7:0] & `GPL_DRV6_MASK; // see RQ13
            if (dec.kind == gpl_pkg::GPL_K_THR6)
                thr6_reg <= pwdata[7:0] & `GPL_THR6_MASK; // see RQ12
            if (dec.kind == gpl_pkg::GPL_K_RSTFN)
                rstfn_reg <= pwdata[7:0] & `GPL_RSTFN_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // effective direction and read value

    always_comb
    begin
        eff_in = pin_ctrl.in_mode;
        // port-12 pins 1..5 are input only whatever the mode bits say
        eff_in[`GPL_SLOT_P12] = pin_ctrl.in_mode[`GPL_SLOT_P12]
                              | `GPL_P12_RO_MASK; // see RQ6
        od_sel = '0;
        od_sel[`GPL_SLOT_P6] = drv6_reg;
    end

    always_comb
    begin
        rd_value = 8'h00;
        unique case (dec.kind)
            gpl_pkg::GPL_K_LATCH:
            begin
                rd_value = (eff_in[dec.slot] & pin_sync[dec.slot])
                         | (~eff_in[dec.slot] & latch_reg[dec.slot]); // see RQ2
                if (dec.slot == `GPL_SLOT_P12)
                begin
                    rd_value = rd_value & `GPL_P12_RD_MASK; // see RQ19
                    if (main_osc_active)
                        rd_value = rd_value & ~`GPL_P12_OSC_MAIN; // see RQ5
                    if (sub_osc_active)
                        rd_value = rd_value & ~`GPL_P12_OSC_SUB; // see RQ5
                end
            end
            gpl_pkg::GPL_K_PULL:  rd_value = pull_sel_reg[dec.slot];
            gpl_pkg::GPL_K_DRV6:  rd_value = drv6_reg;
            gpl_pkg::GPL_K_THR6:  rd_value = thr6_reg;
            gpl_pkg::GPL_K_RSTFN: rd_value = rstfn_reg;
            default:              rd_value = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= rd_fire;
            pslverr <= rd_fire && !dec.valid;
            if (rd_fire)
                prdata <= (dec.valid && !pwrite) ? {24'h00_0000, rd_value}
                                                 : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pads

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pad             <= '0;
            smbus_input_sel <= 2'h0;
            ext_reset_req   <= 1'b0;
        end
        else
        begin
            pad.out <= latch_reg; // see RQ1
            // open drain only pulls low, so a one releases the pin
            pad.oe  <= ~eff_in & ~(od_sel & latch_reg); // see RQ13
            pad.pull <= pull_sel_reg & eff_in // see RQ8 RQ10
                      & ~pin_ctrl.alt_out; // see RQ9
            smbus_input_sel <= thr6_reg[1:0]; // see RQ12
            // shared pin low asks for reset only in reset mode
            ext_reset_req <= !rstfn_reg[`GPL_RESET_PIN_SELECT_BIT_BIT]
                && !pin_sync[`GPL_SLOT_P12][`GPL_RSTPIN_BIT]; // see RQ18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_latch_write: assert property (@(posedge mclk) disable iff (rst) // see RQ3
        (byte_wr && paddr[17:2] == `GPL_IDX_P0)
        |=> latch_reg[0] == $past(pwdata[7:0]))
        else $error("port 0 latch missed its write");

    a_strobe_gate: assert property (@(posedge mclk) disable iff (rst) // see RQ16
        (wr_fire && !pstrb[0]) |=> $stable(latch_reg))
        else $error("latch changed without byte lane 0");

    a_p12_readonly: assert property (@(posedge mclk) disable iff (rst) // see RQ6
        (byte_wr && paddr[17:2] == `GPL_IDX_P12)
        |=> latch_reg[`GPL_SLOT_P12][7:1] == 7'h00)
        else $error("port 12 read-only bits were written");

    a_drive_out: assert property (@(posedge mclk) disable iff (rst) // see RQ1
        // pads still show reset one edge after release
        (!pin_ctrl.in_mode[1][3] && !$past(rst))
        |=> pad.oe[1][3] && pad.out[1][3] == $past(latch_reg[1][3]))
        else $error("output mode pin not driven from latch");

    a_rd_input: assert property (@(posedge mclk) disable iff (rst) // see RQ2
        (rd_fire && !pwrite && paddr[17:2] == `GPL_IDX_P0
         && pin_ctrl.in_mode[0] == 8'hFF)
        |=> pready && prdata[7:0] == $past(pin_sync[0]))
        else $error("input mode read did not return pin level");

    a_osc_zero: assert property (@(posedge mclk) disable iff (rst) // see RQ5
        (rd_fire && !pwrite && paddr[17:2] == `GPL_IDX_P12 && main_osc_active)
        |=> prdata[2:1] == 2'h0)
        else $error("oscillator pins did not read zero");

    a_pull_gate: assert property (@(posedge mclk) disable iff (rst) // see RQ9
        pad.pull[0][2] |-> $past(pull_sel_reg[0][2]
            && pin_ctrl.in_mode[0][2] && !pin_ctrl.alt_out[0][2]))
        else $error("pull-up on a pin that may not have one");

    a_open_drain: assert property (@(posedge mclk) disable iff (rst) // see RQ13
        (drv6_reg[0] && latch_reg[`GPL_SLOT_P6][0]) |=> !pad.oe[`GPL_SLOT_P6][0])
        else $error("open drain pin drove high");

    a_reset_pin: assert property (@(posedge mclk) disable iff (rst) // see RQ17
        ext_reset_req |-> $past(!rstfn_reg[0])
            && $past(!pin_sync[`GPL_SLOT_P12][`GPL_RSTPIN_BIT]))
        else $error("reset request while pin is a port");

endmodule

`default_nettype wire

// ===== tb/gpl_port_ctrl_test.sv
// self-checking bench of the port latch and pull-up block
`timescale 1ns/1ps
`default_nettype none

`include "gpl_params.svh"

module gpl_port_ctrl_test;

    ////////////////////////////////////////////////////////////////////////
    logic                       mclk            = 1'b0;
    logic                       rst             = 1'b1;
    logic                       psel            = 1'b0;
    logic                       penable         = 1'b0;
    logic                       pwrite          = 1'b0;
    logic [17:0]                paddr           = 18'h00000;
    logic [31:0]                pwdata          = 32'h00000000;
    logic [3:0]                 pstrb           = 4'hF;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    gpl_pkg::gpl_pin_ctrl_type  pin_ctrl        = '0;
    logic                       main_osc_active = 1'b0;
    logic                       sub_osc_active  = 1'b0;
    // pin 125 starts high so no external reset is requested
    gpl_pkg::gpl_bytes_type     pin_in          = 64'h2000000000000000;
    gpl_pkg::gpl_pad_type       pad;
    logic [1:0]                 smbus_input_sel;
    logic                       ext_reset_req;
    int                         n_fail          = 0;
    int                         tests_run       = 0;

    localparam logic [15:0] IDX [18] = '{`GPL_IDX_P0, `GPL_IDX_P1,
        `GPL_IDX_P2, `GPL_IDX_P3, `GPL_IDX_P4, `GPL_IDX_P6, `GPL_IDX_P7,
        `GPL_IDX_P12, `GPL_IDX_DRV6, `GPL_IDX_PU0, `GPL_IDX_PU1,
        `GPL_IDX_PU3, `GPL_IDX_PU4, `GPL_IDX_PU6, `GPL_IDX_PU7,
        `GPL_IDX_PULLUP_SEL_PORT12, `GPL_IDX_THR6, `GPL_IDX_RSTFN};
    // port 12 reads its input-only pins, so bit 5 shows the high pin
    localparam logic [7:0] RSTV [18] = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h20, 8'h00, 8'h00};

    always #12.5 mclk = ~mclk;

    gpl_port_ctrl DUT (
        .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .pin_ctrl, .main_osc_active,
        .sub_osc_active, .pin_in, .pad, .smbus_input_sel, .ext_reset_req
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (n_fail == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [17:0] a,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic err);
        int k;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, wd};
        @(posedge mclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge mclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            n_fail++;
            print_verdict();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, {idx, 2'b00}, d, r, e);
        chk("write_err", {7'h00, e}, 8'h00);
    endtask

    task automatic rdc(input string nm, input logic [15:0] idx,
                       input logic [7:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, {idx, 2'b00}, 8'h00, r, e);
        chk(nm, r[7:0], exp);
    endtask

    // lets registered pads and the three-stage pin sync settle
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        settle(8);
        for (int i = 0; i < 18; i++)
            rdc("reset_value", IDX[i], RSTV[i]);
        chk("reset_shared_input_pin_pull", {7'h00, pad.pull[7][5]}, 8'h01);
        chk("no_rst_req", {7'h00, ext_reset_req}, 8'h00);
    endtask

    task automatic t_latch();
        logic [31:0] r;
        logic        e;
        wr(`GPL_IDX_P0, 8'hA5);
        rdc("p0_out", `GPL_IDX_P0, 8'hA5);
        settle(2);
        chk("p0_pad", pad.out[0], 8'hA5);
        chk("p0_oe", pad.oe[0], 8'hFF);
        @(posedge mclk);
        pin_ctrl.in_mode[0] <= 8'hFF;
        pin_in[0]           <= 8'h3C;
        settle(6);
        rdc("p0_in", `GPL_IDX_P0, 8'h3C);
        wr(`GPL_IDX_P0, 8'h5A);
        settle(2);
        chk("p0_in_oe", pad.oe[0], 8'h00);
        @(posedge mclk);
        pin_ctrl.in_mode[0] <= 8'h00;
        settle(2);
        rdc("p0_held", `GPL_IDX_P0, 8'h5A);
        chk("p0_held_pad", pad.out[0], 8'h5A);
        wr(`GPL_IDX_P1, 8'h81);
        apb(1'b0, {`GPL_IDX_P1, 2'b00}, 8'h00, r, e);
        wr(`GPL_IDX_P1, r[7:0] | 8'h08);
        rdc("p1_rmw", `GPL_IDX_P1, 8'h89);
    endtask

    task automatic t_p12();
        @(posedge mclk);
        pin_in[7] <= 8'hFE;
        wr(`GPL_IDX_P12, 8'hFF);
        settle(6);
        rdc("p12_plain", `GPL_IDX_P12, 8'h3F);
        @(posedge mclk);
        main_osc_active <= 1'b1;
        rdc("p12_main", `GPL_IDX_P12, 8'h39);
        @(posedge mclk);
        sub_osc_active <= 1'b1;
        rdc("p12_both", `GPL_IDX_P12, 8'h21);
        @(posedge mclk);
        main_osc_active <= 1'b0;
        sub_osc_active  <= 1'b0;
        pin_in[7]       <= 8'h20;
        wr(`GPL_IDX_P12, 8'h00);
        settle(6);
        rdc("p12_ro", `GPL_IDX_P12, 8'h20);
    endtask

    task automatic t_pull();
        @(posedge mclk);
        pin_ctrl.in_mode[0] <= 8'h0F;
        pin_ctrl.alt_out[0] <= 8'h03;
        wr(`GPL_IDX_PU0, 8'hFF);
        rdc("pu0", `GPL_IDX_PU0, 8'hFF);
        settle(2);
        chk("pu0_pad", pad.pull[0], 8'h0C);
        wr(`GPL_IDX_PU0, 8'h05);
        settle(2);
        chk("pu0_pad_sel", pad.pull[0], 8'h04);
    endtask

    task automatic t_port6();
        wr(`GPL_IDX_DRV6, 8'hFF);
        rdc("drv6", `GPL_IDX_DRV6, 8'h0F);
        wr(`GPL_IDX_P6, 8'h05);
        settle(2);
        chk("p6_od_oe", pad.oe[5], 8'hFA);
        wr(`GPL_IDX_DRV6, 8'h00);
        settle(2);
        chk("p6_cmos_oe", pad.oe[5], 8'hFF);
        wr(`GPL_IDX_THR6, 8'hFF);
        rdc("thr6", `GPL_IDX_THR6, 8'h03);
        chk("smbus_sel", {6'h00, smbus_input_sel}, 8'h03);
    endtask

    task automatic t_rstpin();
        @(posedge mclk);
        pin_in[7] <= 8'h00;
        settle(6);
        chk("rst_req_on", {7'h00, ext_reset_req}, 8'h01);
        wr(`GPL_IDX_RSTFN, 8'hFF);
        settle(2);
        chk("rst_req_off", {7'h00, ext_reset_req}, 8'h00);
        rdc("rstfn", `GPL_IDX_RSTFN, 8'h01);
        @(posedge mclk);
        pin_in[7] <= 8'h20;
        settle(6);
        rdc("reset_shared_input_pin_in", `GPL_IDX_P12, 8'h20);
    endtask

    // unmapped word and misaligned address refused; no lane 0, no write
    task automatic t_unmapped();
        logic [31:0] r;
        logic        e;
        apb(1'b1, {16'hFF05, 2'b00}, 8'hFF, r, e);
        chk("unmapped_err", {7'h00, e}, 8'h01);
        apb(1'b0, {`GPL_IDX_P0, 2'b01}, 8'h00, r, e);
        chk("misaligned_err", {7'h00, e}, 8'h01);
        chk("misaligned_rd", r[7:0], 8'h00);
        @(posedge mclk);
        pstrb <= 4'hE;
        apb(1'b1, {`GPL_IDX_P1, 2'b00}, 8'h00, r, e);
        pstrb <= 4'hF;
        rdc("strobe_gate", `GPL_IDX_P1, 8'h89);
    endtask

    task automatic t_rerun();
        @(posedge mclk);
        rst <= 1'b1;
        settle(3);
        @(posedge mclk);
        rst <= 1'b0;
        settle(2);
        chk("rerun_no_req", {7'h00, ext_reset_req}, 8'h00);
        settle(4);
        rdc("rerun_p1", `GPL_IDX_P1, 8'h00);
        rdc("rerun_pu0", `GPL_IDX_PU0, 8'h00);
        rdc("rerun_pullup_sel_port12", `GPL_IDX_PULLUP_SEL_PORT12, 8'h20);
        rdc("rerun_rstfn", `GPL_IDX_RSTFN, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_latch();
        t_p12();
        t_pull();
        t_port6();
        t_rstpin();
        t_unmapped();
        t_rerun();
        print_verdict();
    end

endmodule

`default_nettype wire
